// ==== verilog/bsc_regs.svh ====
// Register map constants of the bias supply configuration bank.
// Assumes byte-wide registers on a plain address/strobe port and a 125 MHz clock.
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// Register offsets.
`define BSC_OFF_IO       8'h04
`define BSC_OFF_MISC     8'h05
`define BSC_OFF_SS1      8'h06
`define BSC_OFF_SS2      8'h07
`define BSC_OFF_RST      8'h08

// Field positions.
`define BSC_IO_LSB       0
`define BSC_RATE_BIT     2
`define BSC_CORE_LSB     0
`define BSC_SS_LSB       0
`define BSC_RST_LSB      0

// Implemented-bit masks.
`define BSC_MASK_IO      8'h03
`define BSC_MASK_MISC    8'h07
`define BSC_MASK_SS      8'h07
`define BSC_MASK_RST     8'h03

// Reset values.
`define BSC_RST_IO       2'h0
`define BSC_RST_RATE     1'h0
`define BSC_RST_CORE     2'h0
`define BSC_RST_SS1      3'h0
`define BSC_RST_SS2      3'h0
`define BSC_RST_PULSE    2'h1

// Timing, in microseconds or soft-start steps, and the clock rate.
`define BSC_CLK_MHZ      125
`define BSC_SS_STEP_US   500
`define BSC_SS2_STEPS0   8
`define BSC_RST_BASE_US  2000
`define BSC_GATE_STEP_US 5000

`endif

// ==== verilog/bsc_pkg.sv ====
// Types shared by the bias supply configuration bank.
// Assumes the constants of bsc_regs.svh for widths and values.
package bsc_pkg;

   typedef struct packed {
      logic [1:0] io_sel;
      logic       rate;
      logic [1:0] core_sel;
      logic [2:0] bss;
      logic [2:0] oss;
      logic [1:0] pulse_len;
      logic [7:0] rdata;
      logic       ldo_en;
      logic       en_prev;
      logic       gate_prev;
      logic       ss1_on;
      logic       ss2_on;
      logic       rst_n;
      logic       done;
   } bsc_state_type;

   typedef struct packed {
      logic [31:0] cnt;
      logic        busy;
      logic        done;
   } bsc_tmr_state_type;

endpackage

// ==== verilog/bsc_timer_if.sv ====
// Control bundle between the configuration bank and one interval timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface bsc_timer_if;
   logic        start;
   logic        abort;
   logic [31:0] cycles;
   logic        busy;
   logic        done;
   modport ctrl (output start, output abort, output cycles, input busy, input done);
   modport tmr  (input start, input abort, input cycles, output busy, output done);
endinterface // bsc_timer_if

// ==== verilog/bsc_sync2.sv ====
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the input is a slow level; a pulse shorter than one clock can be missed.
`timescale 1ns/1ns
module bsc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bsc_sync_type;

   bsc_sync_type st;
   bsc_sync_type next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule // bsc_sync2

// ==== verilog/bsc_timer.sv ====
// One-shot interval timer: busy for the loaded number of cycles, then done.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
module bsc_timer (
   input  wire logic   clk,
   input  wire logic   srst,
   bsc_timer_if.tmr    tif
);
   bsc_pkg::bsc_tmr_state_type st;
   bsc_pkg::bsc_tmr_state_type next_st;

   always_comb begin
      next_st = st;
      if (tif.abort) begin
         next_st.busy = 1'b0;
         next_st.done = 1'b0;
      end else if (tif.start) begin
         next_st.cnt  = tif.cycles;
         next_st.busy = 1'b1;
         next_st.done = 1'b0;
      end else if (st.busy) begin
         // A zero load still takes one cycle, so done never races start.
         if (st.cnt <= 32'h1) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tif.busy = st.busy;
   assign tif.done = st.done;

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] run;
   logic [31:0] want;

   always_ff @(posedge clk) begin
      if (srst || tif.start || tif.abort) begin
         run  <= 32'h0;
         want <= (tif.cycles == 32'h0) ? 32'h1 : tif.cycles;
      end else if (st.busy) begin
         run <= run + 32'h1;
      end
   end

   a_timer_exact_len:
   assert property (@(posedge clk) disable iff (srst) $rose(st.done) |-> run == want)
      else $error("Timer finished after the wrong number of cycles.");
endmodule // bsc_timer

// ==== verilog/bsc_config_regs.sv ====
// Bias supply configuration bank: five byte registers and the start-up timing they steer.
// Assumes a plain register port on clk; enable and gate-ready arrive from pins.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "bsc_regs.svh"
module bsc_config_regs #(
   parameter int unsigned SS_STEP_CYC   = `BSC_SS_STEP_US * `BSC_CLK_MHZ,
   parameter int unsigned RST_BASE_CYC  = `BSC_RST_BASE_US * `BSC_CLK_MHZ,
   parameter int unsigned GATE_STEP_CYC = `BSC_GATE_STEP_US * `BSC_CLK_MHZ
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output      logic [7:0] rdata,
   input  wire logic       enable_pin,
   input  wire logic       gate_supply_ready,
   input  wire logic [2:0] gate_shaping_delay_field,
   output      logic [1:0] io_supply_select,
   output      logic       ldo_enable,
   output      logic       boost1_switch_rate,
   output      logic [1:0] core_supply_select,
   output      logic       buck_ldo_softstart_on,
   output      logic       boost_softstart_on,
   output      logic       startup_reset_n,
   output      logic       powerup_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs and timers.

   logic [1:0] pins_s;
   logic       en_s;
   logic       gate_s;

   bsc_sync2 #(
      .W    (2)
   ) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({enable_pin, gate_supply_ready}),
      .q    (pins_s)
   );

   assign en_s   = pins_s[1];
   assign gate_s = pins_s[0];

   bsc_timer_if t_ss1 ();
   bsc_timer_if t_ss2 ();
   bsc_timer_if t_rst ();
   bsc_timer_if t_gate ();

   bsc_timer u_ss1  (.clk (clk), .srst (srst), .tif (t_ss1));
   bsc_timer u_ss2  (.clk (clk), .srst (srst), .tif (t_ss2));
   bsc_timer u_rst  (.clk (clk), .srst (srst), .tif (t_rst));
   bsc_timer u_gate (.clk (clk), .srst (srst), .tif (t_gate));

   bsc_pkg::bsc_state_type st;
   bsc_pkg::bsc_state_type next_st;

   logic en_rise;
   logic gate_rise;
   logic ss1_end;

   assign en_rise   = en_s & ~st.en_prev;
   assign gate_rise = en_s & gate_s & ~st.gate_prev;
   assign ss1_end   = st.ss1_on & ~t_ss1.busy & t_ss1.done;

   // Dropping the enable abandons the whole sequence; it restarts on the next rise.
   assign t_ss1.abort  = ~en_s;
   assign t_ss2.abort  = ~en_s;
   assign t_rst.abort  = ~en_s;
   assign t_gate.abort = ~en_s;

   assign t_ss1.start  = en_rise;
   assign t_rst.start  = en_rise;
   assign t_ss2.start  = ss1_end;
   assign t_gate.start = gate_rise;

   assign t_ss1.cycles = 32'(({29'h0, st.bss} + 32'h1) * SS_STEP_CYC);
   assign t_ss2.cycles = 32'(({29'h0, st.oss} + 32'(`BSC_SS2_STEPS0)) * SS_STEP_CYC);
   assign t_rst.cycles = 32'(RST_BASE_CYC) << st.pulse_len;
   assign t_gate.cycles = 32'({29'h0, gate_shaping_delay_field} * GATE_STEP_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Register port and sequence state.

   always_comb begin
      next_st       = st;
      next_st.rdata = 8'h00;
      if (wr) begin
         // Only implemented bits are captured; the rest of the byte is dropped.
         case (addr)
            `BSC_OFF_IO: begin
               next_st.io_sel = wdata[`BSC_IO_LSB +: 2];
            end
            `BSC_OFF_MISC: begin
               next_st.rate     = wdata[`BSC_RATE_BIT];
               next_st.core_sel = wdata[`BSC_CORE_LSB +: 2];
            end
            `BSC_OFF_SS1: begin
               next_st.bss = wdata[`BSC_SS_LSB +: 3];
            end
            `BSC_OFF_SS2: begin
               next_st.oss = wdata[`BSC_SS_LSB +: 3];
            end
            `BSC_OFF_RST: begin
               next_st.pulse_len = wdata[`BSC_RST_LSB +: 2];
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
      if (rd) begin
         // Unmapped addresses and unused bits read zero.
         case (addr)
            `BSC_OFF_IO:   next_st.rdata = {6'h00, st.io_sel};
            `BSC_OFF_MISC: next_st.rdata = {5'h00, st.rate, st.core_sel};
            `BSC_OFF_SS1:  next_st.rdata = {5'h00, st.bss};
            `BSC_OFF_SS2:  next_st.rdata = {5'h00, st.oss};
            `BSC_OFF_RST:  next_st.rdata = {6'h00, st.pulse_len};
            default:       next_st.rdata = 8'h00;
         endcase
      end
      // The regulator runs only for the two upper IO codes.
      next_st.ldo_en    = next_st.io_sel[1];
      next_st.en_prev   = en_s;
      // Gate history clears while disabled, so a supply already up at enable still starts.
      next_st.gate_prev = gate_s & en_s;
      next_st.ss1_on    = t_ss1.busy;
      next_st.ss2_on    = t_ss2.busy;
      next_st.rst_n     = en_s & t_rst.done;
      // Done waits for the gate-shaping delay, not merely the gate supply.
      next_st.done      = en_s & t_gate.done;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '{io_sel: `BSC_RST_IO, rate: `BSC_RST_RATE, core_sel: `BSC_RST_CORE,
                 bss: `BSC_RST_SS1, oss: `BSC_RST_SS2, pulse_len: `BSC_RST_PULSE,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign rdata                 = st.rdata;
   assign io_supply_select      = st.io_sel;
   assign ldo_enable            = st.ldo_en;
   assign boost1_switch_rate    = st.rate;
   assign core_supply_select    = st.core_sel;
   assign buck_ldo_softstart_on = st.ss1_on;
   assign boost_softstart_on    = st.ss2_on;
   assign startup_reset_n       = st.rst_n;
   assign powerup_done          = st.done;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_unused_bits_zero:
   assert property (@(posedge clk) disable iff (srst)
      rd && (addr == `BSC_OFF_IO || addr == `BSC_OFF_RST) |=> rdata[7:2] == 6'h00)
      else $error("Unimplemented bits read nonzero.");

   a_io_write_takes:
   assert property (@(posedge clk) disable iff (srst)
      wr && addr == `BSC_OFF_IO |=> io_supply_select == $past(wdata[1:0])
         && ldo_enable == $past(wdata[1]))
      else $error("IO select or regulator enable wrong after write.");

   a_rate_write_takes:
   assert property (@(posedge clk) disable iff (srst)
      wr && addr == `BSC_OFF_MISC |=> boost1_switch_rate == $past(wdata[2]))
      else $error("Boost-1 rate bit wrong after write.");

   a_core_readback:
   assert property (@(posedge clk) disable iff (srst)
      wr && addr == `BSC_OFF_MISC ##1 rd && addr == `BSC_OFF_MISC
         |=> rdata == {5'h00, $past(wdata[2:0], 2)})
      else $error("Converter control did not read back as written.");

   a_ss1_load:
   assert property (@(posedge clk) disable iff (srst)
      t_ss1.start && !t_ss1.abort |=> ##1 buck_ldo_softstart_on ##1 buck_ldo_softstart_on)
      else $error("Buck soft-start did not begin after enable.");

   a_ss2_after_ss1:
   assert property (@(posedge clk) disable iff (srst)
      $fell(buck_ldo_softstart_on) && en_s |-> ##[1:3] boost_softstart_on)
      else $error("Boost soft-start did not follow the buck soft-start.");

   a_pulse_low_first:
   assert property (@(posedge clk) disable iff (srst)
      en_rise |=> !startup_reset_n ##1 !startup_reset_n)
      else $error("Start-up reset pulse missing after enable.");

   a_done_after_gate:
   assert property (@(posedge clk) disable iff (srst)
      $rose(powerup_done) |-> $past(t_gate.done) && !t_gate.busy)
      else $error("Power-up marked done before the gate-shaping delay.");

   a_fields_hold:
   assert property (@(posedge clk) disable iff (srst)
      !(wr && addr == `BSC_OFF_SS2) |=> $stable(st.oss))
      else $error("Boost soft-start field changed without a write.");

   a_rdata_one_cycle:
   assert property (@(posedge clk) disable iff (srst)
      !rd |=> rdata == 8'h00)
      else $error("Read data stood outside its cycle.");

   a_misc_ss_unused_zero:
   assert property (@(posedge clk) disable iff (srst)
      rd && (addr == `BSC_OFF_MISC || addr == `BSC_OFF_SS1 || addr == `BSC_OFF_SS2)
      |=> rdata[7:3] == 5'h00)
      else $error("Unimplemented converter or soft-start bits read nonzero.");

   a_unmapped_read_zero:
   assert property (@(posedge clk) disable iff (srst)
      rd && (addr < `BSC_OFF_IO || addr > `BSC_OFF_RST) |=> rdata == 8'h00)
      else $error("Unmapped address read nonzero.");

   a_io_readback:
   assert property (@(posedge clk) disable iff (srst)
      rd && addr == `BSC_OFF_IO |=> rdata == {6'h00, $past(io_supply_select)})
      else $error("IO field did not read back as held.");

   a_ldo_follows_io:
   assert property (@(posedge clk) disable iff (srst)
      ldo_enable == io_supply_select[1])
      else $error("Regulator enable disagrees with the IO code.");

   a_rate_readback:
   assert property (@(posedge clk) disable iff (srst)
      rd && addr == `BSC_OFF_MISC |=> rdata[2] == $past(boost1_switch_rate))
      else $error("Boost-1 rate bit did not read back.");

   a_core_write_takes:
   assert property (@(posedge clk) disable iff (srst)
      wr && addr == `BSC_OFF_MISC |=> core_supply_select == $past(wdata[1:0]))
      else $error("Core buck code wrong after write.");

   a_ss1_range:
   assert property (@(posedge clk) disable iff (srst)
      t_ss1.start |-> t_ss1.cycles >= SS_STEP_CYC && t_ss1.cycles <= 8 * SS_STEP_CYC)
      else $error("Buck soft-start length outside its range.");

   a_ss1_readback:
   assert property (@(posedge clk) disable iff (srst)
      rd && addr == `BSC_OFF_SS1 |=> rdata == {5'h00, $past(st.bss)})
      else $error("Buck soft-start code did not read back as held.");

   a_ss2_range:
   assert property (@(posedge clk) disable iff (srst)
      t_ss2.start |-> t_ss2.cycles >= 8 * SS_STEP_CYC && t_ss2.cycles <= 15 * SS_STEP_CYC)
      else $error("Boost soft-start length outside its range.");

   a_ss2_readback:
   assert property (@(posedge clk) disable iff (srst)
      rd && addr == `BSC_OFF_SS2 |=> rdata == {5'h00, $past(st.oss)})
      else $error("Boost soft-start code did not read back as held.");

   a_ss_off_disabled:
   assert property (@(posedge clk) disable iff (srst)
      !en_s |=> ##1 !buck_ldo_softstart_on && !boost_softstart_on)
      else $error("Soft-start flag stayed up after the enable dropped.");

   a_pulse_choice:
   assert property (@(posedge clk) disable iff (srst)
      t_rst.start |-> t_rst.cycles == RST_BASE_CYC || t_rst.cycles == 2 * RST_BASE_CYC
         || t_rst.cycles == 4 * RST_BASE_CYC || t_rst.cycles == 8 * RST_BASE_CYC)
      else $error("Start-up reset pulse length is not one of the four choices.");

   a_pulse_readback:
   assert property (@(posedge clk) disable iff (srst)
      rd && addr == `BSC_OFF_RST |=> rdata == {6'h00, $past(st.pulse_len)})
      else $error("Reset pulse code did not read back as held.");

   a_gate_range:
   assert property (@(posedge clk) disable iff (srst)
      t_gate.start |-> t_gate.cycles <= 7 * GATE_STEP_CYC)
      else $error("Gate-shaping delay longer than the largest code.");

   a_done_needs_enable:
   assert property (@(posedge clk) disable iff (srst)
      !en_s |=> !powerup_done && !startup_reset_n)
      else $error("Power-up status stayed up after the enable dropped.");

   a_io_hold:
   assert property (@(posedge clk) disable iff (srst)
      !(wr && addr == `BSC_OFF_IO) |=> $stable(io_supply_select))
      else $error("IO field changed without a write.");

   a_misc_hold:
   assert property (@(posedge clk) disable iff (srst)
      !(wr && addr == `BSC_OFF_MISC) |=> $stable(boost1_switch_rate) && $stable(core_supply_select))
      else $error("Converter control changed without a write.");

   c_powerup_done:  cover property (@(posedge clk) disable iff (srst) $rose(powerup_done));
   c_pulse_release: cover property (@(posedge clk) disable iff (srst) $rose(startup_reset_n));
   c_ldo_on:        cover property (@(posedge clk) disable iff (srst) $rose(ldo_enable));
   c_enable_drop:   cover property (@(posedge clk) disable iff (srst) $fell(en_s) && boost_softstart_on);
   c_back_to_back:  cover property (@(posedge clk) disable iff (srst) wr ##1 rd);

endmodule // bsc_config_regs

// ==== verif/bsc_config_regs_bench.sv ====
// Self-checking bench for the bias supply configuration bank.
// Assumes short timer parameters so that a whole start-up fits in a few hundred cycles.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module bsc_config_regs_bench;
   localparam int SS = 4;
   localparam int RB = 8;
   localparam int GS = 5;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       enable_pin = 1'b0;
   logic       gate_supply_ready = 1'b0;
   logic [2:0] gate_shaping_delay_field = 3'h2;
   logic [1:0] io_supply_select;
   logic       ldo_enable;
   logic       boost1_switch_rate;
   logic [1:0] core_supply_select;
   logic       buck_ldo_softstart_on;
   logic       boost_softstart_on;
   logic       startup_reset_n;
   logic       powerup_done;
   int         err_total = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         n_ss1 = 0;
   int         n_ss2 = 0;
   int         n_rst = 0;
   int         w;
   logic [7:0] d;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [5:0] o;
   } bsc_row_type;
   bsc_row_type rows [12] = '{
      '{8'h04, 8'hfc, 8'h00, 6'h00}, '{8'h04, 8'h01, 8'h01, 6'h10},
      '{8'h04, 8'hfa, 8'h02, 6'h28}, '{8'h04, 8'h03, 8'h03, 6'h38},
      '{8'h05, 8'hfb, 8'h03, 6'h3b}, '{8'h05, 8'h04, 8'h04, 6'h3c},
      '{8'h05, 8'h06, 8'h06, 6'h3e}, '{8'h06, 8'hf2, 8'h02, 6'h3e},
      '{8'h07, 8'h09, 8'h01, 6'h3e}, '{8'h08, 8'hff, 8'h03, 6'h3e},
      '{8'h09, 8'hff, 8'h00, 6'h3e}, '{8'h03, 8'h5a, 8'h00, 6'h3e}};

   always #4 clk = ~clk;

   bsc_config_regs #(.SS_STEP_CYC(SS), .RST_BASE_CYC(RB), .GATE_STEP_CYC(GS)) u_bsc_config_regs (
      .clk                      (clk),
      .srst                     (srst),
      .addr                     (addr),
      .wdata                    (wdata),
      .wr                       (wr),
      .rd                       (rd),
      .rdata                    (rdata),
      .enable_pin               (enable_pin),
      .gate_supply_ready        (gate_supply_ready),
      .gate_shaping_delay_field (gate_shaping_delay_field),
      .io_supply_select         (io_supply_select),
      .ldo_enable               (ldo_enable),
      .boost1_switch_rate       (boost1_switch_rate),
      .core_supply_select       (core_supply_select),
      .buck_ldo_softstart_on    (buck_ldo_softstart_on),
      .boost_softstart_on       (boost_softstart_on),
      .startup_reset_n          (startup_reset_n),
      .powerup_done             (powerup_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Pulse lengths are counted here so the sequence needs no cycle-exact polling.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (buck_ldo_softstart_on === 1'b1) n_ss1 <= n_ss1 + 1;
      if (boost_softstart_on === 1'b1) n_ss2 <= n_ss2 + 1;
      if (enable_pin && startup_reset_n === 1'b0) n_rst <= n_rst + 1;
      if (cyc == 3000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      `CHK("reset outputs", 8'h00, {io_supply_select, ldo_enable, boost1_switch_rate,
           core_supply_select, startup_reset_n})
      for (int i = 4; i <= 8; i++) begin
         rd_reg(i[7:0], d);
         `CHK("reset value", (i == 8) ? 8'h01 : 8'h00, d)
      end
      $display("test reset values done");
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].wd);
         `CHK("outputs", rows[i].o, {io_supply_select, ldo_enable, boost1_switch_rate,
              core_supply_select})
         rd_reg(rows[i].a, d);
         `CHK("readback", rows[i].rd, d)
      end
      $display("test register rows done");
      rd_reg(8'h04, d);
      `CHK("io held", 8'h03, d)
      rd_reg(8'h05, d);
      `CHK("misc held", 8'h06, d)
      $display("test hold done");
      // Soft-start code 2 gives 3 steps, boost code 1 gives 9 steps, pulse code 1 gives 2 bases.
      wr_reg(8'h08, 8'h01);
      n_ss1 = 0;
      n_ss2 = 0;
      n_rst = 0;
      @(posedge clk);
      enable_pin <= 1'b1;
      repeat (80) @(posedge clk);
      #1;
      `CHK("done before gate", 1'b0, powerup_done)
      `CHK("buck softstart len", 3 * SS, n_ss1)
      `CHK("boost softstart len", 9 * SS, n_ss2)
      `CHK("reset pulse len", 1'b1, n_rst >= 2 * RB && n_rst <= 2 * RB + 4)
      `CHK("reset released", 1'b1, startup_reset_n)
      @(posedge clk);
      gate_supply_ready <= 1'b1;
      w = 0;
      while (powerup_done !== 1'b1 && w < 40) begin
         @(posedge clk);
         #1;
         w++;
      end
      `CHK("gate delay", 1'b1, w >= 2 * GS && w <= 2 * GS + 6)
      @(posedge clk);
      enable_pin <= 1'b0;
      gate_supply_ready <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      `CHK("abort", 2'b00, {powerup_done, startup_reset_n})
      $display("test start-up sequence done");
      @(posedge clk);
      gate_shaping_delay_field <= 3'h0;
      enable_pin <= 1'b1;
      repeat (60) @(posedge clk);
      gate_supply_ready <= 1'b1;
      w = 0;
      while (powerup_done !== 1'b1 && w < 40) begin
         @(posedge clk);
         #1;
         w++;
      end
      `CHK("zero gate delay", 1'b1, w <= 6)
      // The IO field is written only once the enable is high and power-up is over.
      wr_reg(8'h04, 8'h02);
      `CHK("io after power-up", 3'h5, {io_supply_select, ldo_enable})
      @(posedge clk);
      addr <= 8'h05;
      wdata <= 8'h07;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("write then read", 8'h07, rdata)
      `CHK("rate and core", 3'h7, {boost1_switch_rate, core_supply_select})
      @(posedge clk);
      #1;
      `CHK("read data gone", 8'h00, rdata)
      $display("test late write and back-to-back access done");
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_reg(8'h08, d);
      `CHK("pulse after reset", 8'h01, d)
      rd_reg(8'h04, d);
      `CHK("io after reset", 8'h00, d)
      $display("test second reset done");
      finish_test();
   end
endmodule // bsc_config_regs_bench
